// ---- ccv_regs.sv ----
// register bank for charge current, precharge/termination and charge voltage
`timescale 1ns/1ps
//
// Function
// - charge-current register at 0x02, reset 0x91
// - switch full-on bit applies below 700 mA
// - fast-charge field bits 5:0, 20 mA LSB
// - linear to 111011, discrete currents above
// - zero fast-charge current disables charging
// - precharge/termination register at 0x03, reset 0x12
// - precharge bits 7:4, 20 mA offset
// - precharge codes above 1100 clamp 260 mA
// - termination bits 3:0, 20 mA offset
// - termination codes above 1100 clamp 260 mA
// - charge-voltage register at 0x04, reset 0x40
// - voltage bits 7:3, low codes tabled
// - codes 01001 up step 10 mV
// - top-off timer bits 2:1, 15-minute steps
// - recharge bit 0 selects 120/210 mV
// - input limit: 100 mA steps, 100 mA offset
module ccv_regs (
	input  wire logic                  clk,              // 100 MHz
	input  wire logic                  rst_n,            // sync, power-on
	input  wire logic                  reg_wr,           // write strobe
	input  wire logic                  reg_rd,           // read strobe
	input  wire logic [7:0]            reg_addr,         // byte address
	input  wire logic [7:0]            reg_wdata,        // write data
	input  wire logic                  reg_reset_req,    // register reset
	input  wire logic                  watchdog_expired, // watchdog pulse
	input  wire logic [4:0]            input_current_limit, // 100 mA code
	output logic      [7:0]            reg_rdata,        // read data
	output logic                       reg_rvalid,       // read answered
	output logic                       reg_addr_hit,     // address mapped
	output ccv_pkg::ccv_setpoint_t     setpoint          // decoded settings
);

	////////////////////////////////////////////////////////////////////////
	// register storage

	logic [7:0] chg_cur_q;   // charge_current_limit
	logic [7:0] pre_term_q;  // precharge_and_termination_current
	logic [7:0] chg_volt_q;  // charge_voltage_limit

	// write decode; one function serves all three registers
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction : hit

	// charge-current: switch bit only on power-on or register reset, field also on wd
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			chg_cur_q <= ccv_pkg::RST_CHG_CUR;
		end else if (reg_reset_req) begin
			chg_cur_q <= ccv_pkg::RST_CHG_CUR;
		end else if (watchdog_expired) begin
			// keep bit 7 and full-on bit, restore current field only
			chg_cur_q <= {chg_cur_q[7:6], ccv_pkg::RST_CHG_CUR[5:0]};
		end else if (reg_wr && hit(reg_addr, ccv_pkg::ADDR_CHG_CUR)) begin
			chg_cur_q <= reg_wdata;
		end
	end

	// precharge / termination: all fields restored by either event
	always_ff @(posedge clk) begin
		if (!rst_n || reg_reset_req || watchdog_expired) begin
			pre_term_q <= ccv_pkg::RST_PRE_TERM;
		end else if (reg_wr && hit(reg_addr, ccv_pkg::ADDR_PRE_TERM)) begin
			pre_term_q <= reg_wdata;
		end
	end

	// charge voltage: all fields restored by either event
	always_ff @(posedge clk) begin
		if (!rst_n || reg_reset_req || watchdog_expired) begin
			chg_volt_q <= ccv_pkg::RST_CHG_VOLT;
		end else if (reg_wr && hit(reg_addr, ccv_pkg::ADDR_CHG_VOLT)) begin
			chg_volt_q <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read port: one cycle latency, unmapped addresses read zero

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata    <= 8'h00;
			reg_rvalid   <= 1'b0;
			reg_addr_hit <= 1'b0;
		end else begin
			reg_rvalid   <= reg_rd;
			reg_addr_hit <= reg_rd && (hit(reg_addr, ccv_pkg::ADDR_CHG_CUR)
				|| hit(reg_addr, ccv_pkg::ADDR_PRE_TERM)
				|| hit(reg_addr, ccv_pkg::ADDR_CHG_VOLT));
			if (!reg_rd) begin
				reg_rdata <= 8'h00;          // idle bus reads low
			end else if (hit(reg_addr, ccv_pkg::ADDR_CHG_CUR)) begin
				reg_rdata <= chg_cur_q;
			end else if (hit(reg_addr, ccv_pkg::ADDR_PRE_TERM)) begin
				reg_rdata <= pre_term_q;
			end else if (hit(reg_addr, ccv_pkg::ADDR_CHG_VOLT)) begin
				reg_rdata <= chg_volt_q;
			end else begin
				reg_rdata <= 8'h00;          // unmapped
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// field decoders

	logic [11:0] fast_ma;     // decoded fast-charge current
	logic [11:0] pre_ma;      // decoded precharge current
	logic [11:0] term_ma;     // decoded termination current
	logic [12:0] vreg_mv;     // decoded charge voltage
	logic [7:0]  topoff_min;  // decoded top-off duration
	logic [12:0] rechg_mv;    // decoded recharge drop

	ccv_current_decode u_cur (
		.fast_charge_current (chg_cur_q[5:0]),
		.precharge_current   (pre_term_q[7:4]),
		.termination_current (pre_term_q[3:0]),
		.fast_charge_ma      (fast_ma),
		.precharge_ma        (pre_ma),
		.termination_ma      (term_ma)
	);

	ccv_voltage_decode u_volt (
		.charge_voltage_setting (chg_volt_q[7:3]),
		.top_off_duration       (chg_volt_q[2:1]),
		.recharge_threshold     (chg_volt_q[ccv_pkg::BIT_RECHARGE]),
		.charge_voltage_mv      (vreg_mv),
		.top_off_minutes        (topoff_min),
		.recharge_drop_mv       (rechg_mv)
	);

	////////////////////////////////////////////////////////////////////////
	// input limit decode and setpoint register

	// input limit is an on-chip signal, so no synchroniser is needed
	logic [11:0] iin_ma;  // input current limit in mA
	always_comb begin
		iin_ma = 12'(({7'h00, input_current_limit} + 12'h001)
			* ccv_pkg::MA_STEP_100);
	end

	// registered so the analog side sees glitch-free settings
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			setpoint <= '0;
		end else begin
			setpoint.fast_charge_ma    <= fast_ma;
			setpoint.precharge_ma      <= pre_ma;
			setpoint.termination_ma    <= term_ma;
			setpoint.charge_voltage_mv <= vreg_mv;
			setpoint.recharge_drop_mv  <= rechg_mv;
			setpoint.top_off_minutes   <= topoff_min;
			// at or above the limit the switch is forced fully on
			setpoint.high_side_switch_full_on <=
				(iin_ma >= ccv_pkg::MA_SWITCH_LIMIT)
				|| chg_cur_q[ccv_pkg::BIT_SWITCH_FULL_ON];
			// zero current blocks charging regardless of other enables
			setpoint.charge_allowed <= (chg_cur_q[5:0] != 6'h00);
		end
	end

endmodule : ccv_regs

// ---- ccv_pkg.sv ----
// package: register map, field layout and decode constants for the charge regs
package ccv_pkg;

	// register byte addresses
	localparam logic [7:0] ADDR_CHG_CUR  = 8'h02;
	localparam logic [7:0] ADDR_PRE_TERM = 8'h03;
	localparam logic [7:0] ADDR_CHG_VOLT = 8'h04;

	// reset values
	localparam logic [7:0] RST_CHG_CUR  = 8'h91;
	localparam logic [7:0] RST_PRE_TERM = 8'h12;
	localparam logic [7:0] RST_CHG_VOLT = 8'h40;

	// field positions
	localparam int BIT_SWITCH_FULL_ON = 6;
	localparam int BIT_RECHARGE       = 0;

	// decode constants
	localparam logic [5:0]  FAST_CHARGE_CURRENT_LINEAR_MAX = 6'h3B;
	localparam logic [3:0]  IPT_CLAMP_CODE  = 4'hC;
	localparam logic [11:0] MA_STEP_20      = 12'h014;
	localparam logic [11:0] MA_STEP_100     = 12'h064;
	localparam logic [11:0] MA_SWITCH_LIMIT = 12'h2BC;
	localparam logic [12:0] MV_VREG_BASE_HI = 13'h10CC;
	localparam logic [12:0] MV_VREG_STEP_HI = 13'h000A;
	localparam logic [12:0] MV_RECHG_SMALL  = 13'h0078;
	localparam logic [12:0] MV_RECHG_LARGE  = 13'h00D2;
	localparam logic [7:0]  MIN_TOPOFF_STEP = 8'h0F;

	// decoded analog setpoints handed to the loops
	typedef struct packed {
		logic [11:0] fast_charge_ma;
		logic [11:0] precharge_ma;
		logic [11:0] termination_ma;
		logic [12:0] charge_voltage_mv;
		logic [12:0] recharge_drop_mv;
		logic [7:0]  top_off_minutes;
		logic        high_side_switch_full_on;
		logic        charge_allowed;
	} ccv_setpoint_t;

endpackage : ccv_pkg

// ---- ccv_current_decode.sv ----
// current field decoders: fast charge, precharge and termination in mA
`timescale 1ns/1ps
module ccv_current_decode (
	input  wire logic [5:0]  fast_charge_current,   // 6-bit code
	input  wire logic [3:0]  precharge_current,     // 4-bit code
	input  wire logic [3:0]  termination_current,   // 4-bit code
	output logic      [11:0] fast_charge_ma,        // decoded mA
	output logic      [11:0] precharge_ma,          // decoded mA
	output logic      [11:0] termination_ma         // decoded mA
);

	// 20 mA offset plus 20 mA per code, codes above 1100 clamp
	function automatic logic [11:0] offset_ma(input logic [3:0] code);
		logic [3:0] c;
		c = (code > ccv_pkg::IPT_CLAMP_CODE) ? ccv_pkg::IPT_CLAMP_CODE : code;
		offset_ma = 12'(({8'h00, c} + 12'h001) * ccv_pkg::MA_STEP_20);
	endfunction : offset_ma

	// fast charge: linear 20 mA steps, discrete points at the top
	always_comb begin
		if (fast_charge_current <= ccv_pkg::FAST_CHARGE_CURRENT_LINEAR_MAX) begin
			fast_charge_ma = 12'({6'h00, fast_charge_current} * ccv_pkg::MA_STEP_20);
		end else begin
			case (fast_charge_current)
				6'h3C:   fast_charge_ma = 12'h50A;      // 1290 mA
				6'h3D:   fast_charge_ma = 12'h550;      // 1360 mA
				6'h3E:   fast_charge_ma = 12'h596;      // 1430 mA
				default: fast_charge_ma = 12'h5DC;      // 1500 mA
			endcase
		end
	end

	// precharge and termination share one clamped mapping
	always_comb begin
		precharge_ma   = offset_ma(precharge_current);
		termination_ma = offset_ma(termination_current);
	end

endmodule : ccv_current_decode

// ---- ccv_voltage_decode.sv ----
// voltage, top-off and recharge field decoders
`timescale 1ns/1ps
module ccv_voltage_decode (
	input  wire logic [4:0]  charge_voltage_setting,  // 5-bit code
	input  wire logic [1:0]  top_off_duration,        // 2-bit code
	input  wire logic        recharge_threshold,      // drop select
	output logic      [12:0] charge_voltage_mv,       // decoded mV
	output logic      [7:0]  top_off_minutes,         // 0 means disabled
	output logic      [12:0] recharge_drop_mv         // decoded mV
);

	// low codes are a coarse table, the rest 10 mV steps from 4.300 V
	always_comb begin
		case (charge_voltage_setting)
			5'h00:   charge_voltage_mv = 13'h0DB0;            // 3504 mV
			5'h01:   charge_voltage_mv = 13'h0E10;            // 3600 mV
			5'h02:   charge_voltage_mv = 13'h0E70;            // 3696 mV
			5'h08:   charge_voltage_mv = 13'h1068;            // 4200 mV
			default: begin
				if (charge_voltage_setting > 5'h08) begin
					charge_voltage_mv = 13'(ccv_pkg::MV_VREG_BASE_HI
						+ {8'h00, charge_voltage_setting - 5'h09}
						* ccv_pkg::MV_VREG_STEP_HI);
				end else begin
					// codes 3..7 are unlisted; hold them at the 3.696 V point
					charge_voltage_mv = 13'h0E70;
				end
			end
		endcase
	end

	// top-off: 15 min per step, 00 disables
	always_comb begin
		top_off_minutes  = 8'({6'h00, top_off_duration} * ccv_pkg::MIN_TOPOFF_STEP);
		recharge_drop_mv = recharge_threshold ? ccv_pkg::MV_RECHG_LARGE
			: ccv_pkg::MV_RECHG_SMALL;
	end

endmodule : ccv_voltage_decode

// ---- ccv_regs_monitor.sv ----
// checker: read handshake, read-back and decoded setpoint relations
`timescale 1ns/1ps
module ccv_regs_monitor (
	input wire logic                   clk,
	input wire logic                   rst_n,
	input wire logic                   reg_wr,
	input wire logic                   reg_rd,
	input wire logic [7:0]             reg_addr,
	input wire logic [7:0]             reg_wdata,
	input wire logic                   reg_reset_req,
	input wire logic                   watchdog_expired,
	input wire logic [4:0]             input_current_limit,
	input wire logic [7:0]             reg_rdata,
	input wire logic                   reg_rvalid,
	input wire logic                   reg_addr_hit,
	input wire ccv_pkg::ccv_setpoint_t setpoint
);
	// the three mapped byte addresses
	wire logic map_hit = reg_addr inside {8'h02, 8'h03, 8'h04};
	wire logic quiet   = !reg_reset_req && !watchdog_expired;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////
	// clean write to 0x02, an idle cycle, then a read of the same place
	sequence s_wr02;
		reg_wr && reg_addr == 8'h02 && quiet;
	endsequence
	sequence s_rd02;
		reg_rd && reg_addr == 8'h02 && quiet;
	endsequence
	a_read_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered");
	a_no_stray: assert property (!reg_rd |=> !reg_rvalid && reg_rdata == 8'h00)
		else $error("read data without a read");
	a_mapped_hit: assert property (reg_rd && map_hit |=> reg_addr_hit)
		else $error("mapped address not hit");
	a_unmapped_zero: assert property (reg_rd && !map_hit |=> !reg_addr_hit && reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_write_readback: assert property (s_wr02 ##1 (!reg_wr && quiet) ##1 s_rd02
		|=> reg_rdata == $past(reg_wdata, 3))
		else $error("read back differs from write");
	a_zero_disables: assert property (setpoint.fast_charge_ma == 12'h000 |-> !setpoint.charge_allowed)
		else $error("charging allowed at zero current");
	a_current_clamp: assert property (setpoint.termination_ma <= 12'h104 && setpoint.precharge_ma <= 12'h104)
		else $error("current above clamp");
	a_switch_limit: assert property (input_current_limit >= 5'h06 [*2] |=> setpoint.high_side_switch_full_on)
		else $error("switch not full on at high limit");
endmodule : ccv_regs_monitor
bind ccv_regs ccv_regs_monitor u_mon (.clk, .rst_n, .reg_wr, .reg_rd,
	.reg_addr, .reg_wdata, .reg_reset_req, .watchdog_expired,
	.input_current_limit, .reg_rdata, .reg_rvalid, .reg_addr_hit, .setpoint);

// ---- ccv_host_model.sv ----
// host model: single-byte read and write strobes at the falling edge
`timescale 1ns/1ps
module ccv_host_model (
	input  wire logic       clk,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid,
	input  wire logic       reg_addr_hit,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata
);
	// idle bus at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'hFF;
		reg_wdata = 8'h00;
	end
	////////////////////////////////////////////////////////////////////////
	// one-cycle write; address and data scrambled once released so a
	// design that samples late sees garbage, not the old value
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : wr
	// one-cycle read; answer taken while it stands
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic h);
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
		h = reg_addr_hit & reg_rvalid;
	endtask : rd
endmodule : ccv_host_model

// ---- tb_ccv_regs.sv ----
// testbench: access, field decode, watchdog and register reset
`timescale 1ns/1ps
module tb_ccv_regs;
	logic                   clk = 1'b0;
	logic                   rst_n = 1'b0;
	logic                   reg_wr;
	logic                   reg_rd;
	logic [7:0]             reg_addr;
	logic [7:0]             reg_wdata;
	logic                   reg_reset_req = 1'b0;
	logic                   watchdog_expired = 1'b0;
	logic [4:0]             input_current_limit = 5'h00;
	logic [7:0]             reg_rdata;
	logic                   reg_rvalid;
	logic                   reg_addr_hit;
	ccv_pkg::ccv_setpoint_t setpoint;
	logic [7:0]             rd_data;
	logic                   rd_hit;
	int                     mismatches = 0;
	int                     checks_done = 0;
	always #5 clk = ~clk;
	ccv_regs uut (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.reg_reset_req, .watchdog_expired, .input_current_limit,
		.reg_rdata, .reg_rvalid, .reg_addr_hit, .setpoint);
	ccv_host_model host (.clk, .reg_rdata, .reg_rvalid, .reg_addr_hit,
		.reg_wr, .reg_rd, .reg_addr, .reg_wdata);
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// read one byte, compare data and the mapped flag
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, rd_data, rd_hit);
		chk(rd_data, e);
		chk(rd_hit, a inside {8'h02, 8'h03, 8'h04});
	endtask : rd_chk
	// expected decodes, worked out from the field weights
	function automatic logic [15:0] exp_fast(input int c);
		return (c <= 59) ? 16'(c * 20) : 16'(1290 + 70 * (c - 60));
	endfunction : exp_fast
	function automatic logic [15:0] exp_ipt(input int c);
		return 16'(((c > 12) ? 13 : c + 1) * 20);
	endfunction : exp_ipt
	function automatic logic [15:0] exp_mv(input int c);
		if (c < 3) return 16'(3504 + 96 * c);
		if (c < 8) return 16'h0E70;
		if (c == 8) return 16'h1068;
		return 16'(4300 + 10 * (c - 9));
	endfunction : exp_mv
	task automatic finish_test;
		if (mismatches == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test
	////////////////////////////////////////////////////////////////////////
	// hang guard, about two and a half times the expected run
	initial begin
		#20000;
		mismatches++;
		finish_test();
	end
	initial begin
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		rd_chk(8'h02, 8'h91);
		rd_chk(8'h03, 8'h12);
		rd_chk(8'h04, 8'h40);
		chk(setpoint.fast_charge_ma, 16'h0154);
		chk(setpoint.precharge_ma, 16'h0028);
		chk(setpoint.termination_ma, 16'h003C);
		chk(setpoint.charge_voltage_mv, 16'h1068);
		chk(setpoint.top_off_minutes, 16'h0000);
		chk(setpoint.recharge_drop_mv, 16'h0078);
		for (int c = 0; c < 64; c++) begin
			host.wr(8'h02, {2'b10, c[5:0]});
			rd_chk(8'h02, {2'b10, c[5:0]});
			chk(setpoint.fast_charge_ma, exp_fast(c));
			chk(setpoint.charge_allowed, c != 0);
		end
		for (int c = 0; c < 16; c++) begin
			host.wr(8'h03, {c[3:0], 4'hF - c[3:0]});
			rd_chk(8'h03, {c[3:0], 4'hF - c[3:0]});
			chk(setpoint.precharge_ma, exp_ipt(c));
			chk(setpoint.termination_ma, exp_ipt(15 - c));
		end
		for (int c = 0; c < 32; c++) begin
			host.wr(8'h04, {c[4:0], c[1:0], c[2]});
			rd_chk(8'h04, {c[4:0], c[1:0], c[2]});
			chk(setpoint.charge_voltage_mv, exp_mv(c));
			chk(setpoint.top_off_minutes, 16'(c % 4 * 15));
			chk(setpoint.recharge_drop_mv, c[2] ? 16'h00D2 : 16'h0078);
		end
		for (int b = 0; b < 2; b++)
			for (int l = 0; l < 32; l++) begin
				host.wr(8'h02, {b[0], b[0], 6'h11});
				input_current_limit = l[4:0];
				rd_chk(8'h02, {b[0], b[0], 6'h11});
				chk(setpoint.high_side_switch_full_on, l >= 6 || b == 1);
			end
		host.wr(8'h05, 8'hAA);
		rd_chk(8'h05, 8'h00);
		rd_chk(8'h01, 8'h00);
		host.wr(8'h03, 8'hFF);
		host.wr(8'h04, 8'hFF);
		host.wr(8'h02, 8'hC5);
		watchdog_expired = 1'b1;
		@(negedge clk);
		watchdog_expired = 1'b0;
		rd_chk(8'h02, 8'hD1);
		rd_chk(8'h03, 8'h12);
		rd_chk(8'h04, 8'h40);
		host.wr(8'h02, 8'h45);
		reg_reset_req = 1'b1;
		@(negedge clk);
		reg_reset_req = 1'b0;
		rd_chk(8'h02, 8'h91);
		host.wr(8'h03, 8'hFF);
		host.wr(8'h04, 8'hFF);
		reg_reset_req = 1'b1;
		@(negedge clk);
		reg_reset_req = 1'b0;
		rd_chk(8'h03, 8'h12);
		rd_chk(8'h04, 8'h40);
		// mid-run power-on reset brings every register back
		host.wr(8'h02, 8'h00);
		host.wr(8'h04, 8'hFF);
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		rd_chk(8'h02, 8'h91);
		rd_chk(8'h04, 8'h40);
		chk(setpoint.charge_allowed, 16'h0001);
		finish_test();
	end
endmodule : tb_ccv_regs
